// ===== src/ucsr_pkg.sv
// constants, field layout and carrier types of the serial control block
// assumes an 8-bit special function register port and a bit-write port
package ucsr_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] UCSR_SERIAL_CONTROL_STATUS_ADDR = 8'h98;
	localparam logic [7:0] UCSR_SERIAL_CONTROL_STATUS_RESET = 8'h00;
	// bit addresses 98h..9Fh hit this register; compare the top five bits
	localparam logic [4:0] UCSR_BIT_ADDR_BASE = 5'h13;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int UCSR_BIT_SHARED = 7;
	localparam int UCSR_BIT_MODE_LO = 6;
	localparam int UCSR_BIT_MULTIPROC = 5;
	localparam int UCSR_BIT_RX_ENABLE = 4;
	localparam int UCSR_BIT_TX_NINTH = 3;
	localparam int UCSR_BIT_RX_NINTH = 2;
	localparam int UCSR_BIT_TX_DONE = 1;
	localparam int UCSR_BIT_RX_DONE = 0;

	// ----------------------------------------
	// bit-rate divisors of the cpu clock, 0 means timer driven
	// ----------------------------------------
	localparam logic [5:0] UCSR_DIV_SHIFT = 6'h06;
	localparam logic [5:0] UCSR_DIV_FIXED_FAST = 6'h10;
	localparam logic [5:0] UCSR_DIV_FIXED_SLOW = 6'h20;
	localparam logic [5:0] UCSR_DIV_VARIABLE = 6'h00;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		UCSR_MODE_SHIFT,
		UCSR_MODE_UART8,
		UCSR_MODE_UART9_FIXED,
		UCSR_MODE_UART9_VAR
	} ucsr_mode_t;

	// one received character as the shift engine reports it
	typedef struct packed {
		logic [7:0] data;
		logic ninth;
		logic stop_ok;
	} ucsr_char_t;

	localparam ucsr_char_t UCSR_CHAR_ZERO = '{8'h00, 1'b0, 1'b0};
endpackage

// ===== src/ucsr_buf2.sv
// two-entry elastic buffer for received characters
// assumes both sides are on clock_i; the drain side may stall at will
`timescale 1ns/1ns
`default_nettype none
module ucsr_buf2
	import ucsr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire ucsr_char_t in_char_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output ucsr_char_t out_char_o
);
	typedef struct packed {
		ucsr_char_t e0;
		ucsr_char_t e1;
		logic [1:0] cnt;
		logic in_ready;
		logic out_valid;
	} ucsr_buf_state_t;

	ucsr_buf_state_t st_r;
	ucsr_buf_state_t st_nxt;
	logic push;
	logic pop;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// entry 0 is always the head, so the output needs no mux
	always_comb begin
		st_nxt = st_r;
		push = in_valid_i && st_r.in_ready;
		pop = out_ready_i && (st_r.cnt != 2'h0);
		if (pop) begin
			st_nxt.e0 = st_r.e1;
		end
		if (push) begin
			if (st_r.cnt == 2'h0 || (st_r.cnt == 2'h1 && pop)) begin
				st_nxt.e0 = in_char_i;
			end else begin
				st_nxt.e1 = in_char_i;
			end
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + 2'h1;
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - 2'h1;
		end
		// registered ready: a full buffer refuses until a word drains
		st_nxt.in_ready = (st_nxt.cnt != 2'h2);
		// valid kept in a flop so the output needs no compare
		st_nxt.out_valid = (st_nxt.cnt != 2'h0);
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_r <= '{UCSR_CHAR_ZERO, UCSR_CHAR_ZERO, 2'h0, 1'b1, 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign in_ready_o = st_r.in_ready;
	assign out_valid_o = st_r.out_valid;
	assign out_char_o = st_r.e0;
endmodule
`default_nettype wire

// ===== src/ucsr_top.sv
// serial port control and status register with its flag logic
// assumes the shift engines and timer sit outside; transmit reports by pulses, receive by valid/ready;
// the power control bits arrive as plain levels from their own register
// in fixed 9-bit mode a change of baud_doubler_i shows on rate_div_o one cycle later, as it is
// registered; bit7_select_i only steers bit 7 and never changes mode_o
//
// Notes on behaviour
// (RULE1) bit 7 shows error flag or mode-high by select
// (RULE2) bad stop bit sets the framing error flag
// (RULE3) framing error stays set until software clears
// (RULE4) mode 00 shift at clk/6, 01 variable uart
// (RULE5) bits 6..0: mode-lo, mp, ren, tb8, rb8, ti, ri
// (RULE6) 9-bit modes, filter on: ninth 0 blocks rx-done
// (RULE7) tx-done set at bit 8 or stop start
// (RULE8) fixed 9-bit mode: clk/16 doubled, else clk/32
// (RULE9) bit-7 write touches only the visible flag
`timescale 1ns/1ns
`default_nettype none
module ucsr_top
	import ucsr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	// special function register port, byte and bit writes
	// a byte write wins over a bit write in the same cycle
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic bit_wr_i,
	input wire logic [7:0] bit_addr_i,
	input wire logic bit_val_i,
	// power control levels
	input wire logic bit7_select_i,
	input wire logic baud_doubler_i,
	// transmit engine events
	input wire logic tx_eighth_end_i,
	input wire logic tx_stop_start_i,
	// receive engine characters
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	input wire ucsr_char_t rx_char_i,
	// received data to the reader
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output ucsr_char_t rd_char_o,
	// control towards the engines
	output ucsr_mode_t mode_o,
	output logic [5:0] rate_div_o,
	output logic rx_enable_o,
	output logic tx_ninth_bit_o,
	output logic multiproc_filter_o
);
	typedef struct packed {
		logic mode_select_hi;
		logic mode_select_lo;
		logic multiproc_filter;
		logic rx_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_done_flag;
		logic framing_error_flag;
		logic [7:0] rdata;
		ucsr_mode_t mode;
		logic [5:0] div;
	} ucsr_state_t;

	ucsr_state_t st_r;
	ucsr_state_t st_nxt;
	logic buf_ready;
	logic take;
	logic byte_wr;
	logic bit_hit;
	// decoded write: which bits change and to what
	logic [7:0] wmask;
	logic [7:0] wval;
	// software view before and after this cycle's write
	logic [7:0] view;
	logic [7:0] cur;
	logic [7:0] upd;
	// event that sets the transmit-done flag in the current mode
	logic tx_event;

	// ----------------------------------------
	// received character buffer
	// ----------------------------------------
	ucsr_buf2 u_buf (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.in_valid_i(rx_valid_i),
		.in_ready_o(buf_ready),
		.in_char_i(rx_char_i),
		.out_valid_o(rd_valid_o),
		.out_ready_i(rd_ready_i),
		.out_char_o(rd_char_o)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		take = rx_valid_i && buf_ready;
		byte_wr = sfr_wr_i && (sfr_addr_i == UCSR_SERIAL_CONTROL_STATUS_ADDR);
		bit_hit = bit_wr_i && (bit_addr_i[7:3] == UCSR_BIT_ADDR_BASE);

		// software view of the register
		view = {bit7_select_i ? st_r.framing_error_flag
			: st_r.mode_select_hi, // [RULE1]
			st_r.mode_select_lo, st_r.multiproc_filter,
			st_r.rx_enable, st_r.tx_ninth_bit, st_r.rx_ninth_bit,
			st_r.tx_done_flag, st_r.rx_done_flag}; // [RULE5]
		// byte write replaces all bits, bit write only the addressed one
		wmask = 8'h00;
		wval = sfr_wdata_i;
		if (byte_wr) begin
			wmask = 8'hFF;
		end else if (bit_hit) begin
			wmask = 8'h01 << bit_addr_i[2:0];
			wval = {8{bit_val_i}};
		end
		upd = (view & ~wmask) | (wval & wmask);
		cur = view;

		// bit 7 lands only on whichever flag is visible; the hidden one
		// keeps its value, so switching the select never loses state
		if (bit7_select_i) begin
			st_nxt.framing_error_flag = upd[UCSR_BIT_SHARED]; // [RULE9]
		end else begin
			st_nxt.mode_select_hi = upd[UCSR_BIT_SHARED]; // [RULE9]
		end
		st_nxt.mode_select_lo = upd[UCSR_BIT_MODE_LO];
		st_nxt.multiproc_filter = upd[UCSR_BIT_MULTIPROC];
		st_nxt.rx_enable = upd[UCSR_BIT_RX_ENABLE];
		st_nxt.tx_ninth_bit = upd[UCSR_BIT_TX_NINTH];
		st_nxt.rx_ninth_bit = upd[UCSR_BIT_RX_NINTH];
		st_nxt.tx_done_flag = upd[UCSR_BIT_TX_DONE];
		st_nxt.rx_done_flag = upd[UCSR_BIT_RX_DONE];

		// hardware sets come last so they win over a same-cycle clear
		tx_event = (st_r.mode == UCSR_MODE_SHIFT) ? tx_eighth_end_i
			: tx_stop_start_i;
		if (tx_event) begin
			st_nxt.tx_done_flag = 1'b1; // [RULE7]
		end

		// a character follows the mode in force when it was framed, not a
		// mode written in the same cycle
		if (take) begin
			unique case (st_r.mode)
				UCSR_MODE_SHIFT: begin
					// no stop bit: ninth bit and error flag left alone
					st_nxt.rx_done_flag = 1'b1;
				end
				UCSR_MODE_UART8: begin
					// ninth flag keeps the stop bit, filter off only
					if (!st_r.multiproc_filter) begin
						st_nxt.rx_ninth_bit = rx_char_i.stop_ok;
					end
					if (!st_r.multiproc_filter || rx_char_i.stop_ok) begin
						st_nxt.rx_done_flag = 1'b1;
					end
				end
				UCSR_MODE_UART9_FIXED, UCSR_MODE_UART9_VAR: begin
					// filter on: ninth 0 is data for another node
					st_nxt.rx_ninth_bit = rx_char_i.ninth;
					if (!st_r.multiproc_filter || rx_char_i.ninth) begin
						st_nxt.rx_done_flag = 1'b1; // [RULE6]
					end
				end
			endcase
			// sticky: only a software write or reset clears it
			if (st_r.mode != UCSR_MODE_SHIFT && !rx_char_i.stop_ok) begin
				st_nxt.framing_error_flag = 1'b1; // [RULE2] [RULE3]
			end
		end

		// registered read data, zero for any other address
		// a read in the cycle of a write returns the value before it
		st_nxt.rdata = 8'h00;
		if (sfr_rd_i && sfr_addr_i == UCSR_SERIAL_CONTROL_STATUS_ADDR) begin
			st_nxt.rdata = cur;
		end
		// mode decode and divisor follow the stored mode bits
		st_nxt.mode = ucsr_mode_t'({st_nxt.mode_select_hi,
			st_nxt.mode_select_lo}); // [RULE4]
		unique case (st_nxt.mode)
			UCSR_MODE_SHIFT: st_nxt.div = UCSR_DIV_SHIFT; // [RULE4]
			UCSR_MODE_UART9_FIXED: begin
				st_nxt.div = baud_doubler_i ? UCSR_DIV_FIXED_FAST
					: UCSR_DIV_FIXED_SLOW; // [RULE8]
			end
			UCSR_MODE_UART8, UCSR_MODE_UART9_VAR: begin
				// timer driven: the engine counts overflows itself
				st_nxt.div = UCSR_DIV_VARIABLE; // [RULE4]
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// synchronous reset clears the hidden error flag as well
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_r <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
				1'b0, UCSR_SERIAL_CONTROL_STATUS_RESET, UCSR_MODE_SHIFT,
				UCSR_DIV_SHIFT};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------
	assign sfr_rdata_o = st_r.rdata;
	// buffer flops drive the receive handshake and the read data
	assign rx_ready_o = buf_ready;
	assign mode_o = st_r.mode;
	assign rate_div_o = st_r.div;
	assign rx_enable_o = st_r.rx_enable;
	assign tx_ninth_bit_o = st_r.tx_ninth_bit;
	assign multiproc_filter_o = st_r.multiproc_filter;
endmodule
`default_nettype wire

// ===== tb/ucsr_checker.sv
// port assertions for the serial control block
// assumes one clock, clock_i, and synchronous rst_i
`timescale 1ns/1ns
`default_nettype none
module ucsr_checker
	import ucsr_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic bit7_select_i,
	input wire logic baud_doubler_i,
	input wire logic rx_ready_o,
	input wire logic rd_valid_o,
	input wire logic rd_ready_i,
	input wire ucsr_char_t rd_char_o,
	input wire ucsr_mode_t mode_o,
	input wire logic [5:0] rate_div_o,
	input wire logic rx_enable_o,
	input wire logic tx_ninth_bit_o,
	input wire logic multiproc_filter_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// register fields as the outputs show them
	logic hit;
	logic hi_q;
	logic [3:0] lo_q;
	assign hit = sfr_rd_i && sfr_addr_i == 8'h98;
	assign hi_q = mode_o[1];
	assign lo_q = {mode_o[0], multiproc_filter_o, rx_enable_o, tx_ninth_bit_o};
	chk_shift_rate: assert property (
		mode_o == UCSR_MODE_SHIFT |-> rate_div_o == UCSR_DIV_SHIFT)
		else $error("shift mode rate wrong");
	chk_uart8_rate: assert property (
		mode_o == UCSR_MODE_UART8 |-> rate_div_o == UCSR_DIV_VARIABLE)
		else $error("uart8 rate wrong");
	chk_fixed_rate: assert property (
		mode_o == UCSR_MODE_UART9_FIXED |-> rate_div_o == ($past(baud_doubler_i)
		? UCSR_DIV_FIXED_FAST : UCSR_DIV_FIXED_SLOW))
		else $error("fixed mode rate wrong");
	chk_low_fields: assert property (
		hit |=> sfr_rdata_o[6:3] == $past(lo_q))
		else $error("bits 6 to 3 read wrong");
	chk_mode_hi_read: assert property (
		hit && !bit7_select_i |=> sfr_rdata_o[7] == $past(hi_q))
		else $error("bit 7 not mode high");
	chk_hidden_kept: assert property (
		sfr_wr_i && sfr_addr_i == 8'h98 && bit7_select_i |=> $stable(hi_q))
		else $error("hidden mode bit written");
	// full buffer must have a word on offer, and a stalled word holds
	chk_full_offers: assert property (!rx_ready_o |-> rd_valid_o)
		else $error("refusing while empty");
	chk_stall_hold: assert property (
		rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_char_o))
		else $error("stalled word changed");
endmodule
bind ucsr_top ucsr_checker chk_u (.clock_i, .rst_i, .sfr_addr_i, .sfr_wr_i,
	.sfr_rd_i, .sfr_rdata_o, .bit7_select_i, .baud_doubler_i, .rx_ready_o,
	.rd_valid_o, .rd_ready_i, .rd_char_o, .mode_o, .rate_div_o, .rx_enable_o,
	.tx_ninth_bit_o, .multiproc_filter_o);
`default_nettype wire

// ===== tb/ucsr_rx_node.sv
// far-side model: receive engine handing characters to the block
// assumes send_i pulses only while rx_valid_o is low
`timescale 1ns/1ns
`default_nettype none
module ucsr_rx_node
	import ucsr_pkg::*;
(
	input wire logic clock_i,
	input wire logic send_i,
	input wire ucsr_char_t char_i,
	input wire logic rx_ready_i,
	output logic rx_valid_o = 1'h0,
	output ucsr_char_t rx_char_o = UCSR_CHAR_ZERO
);
	// hold until taken, then junk so a late sample is caught
	always @(posedge clock_i) begin
		if (send_i) begin
			rx_valid_o <= 1'h1;
			rx_char_o <= char_i;
		end else if (rx_valid_o && rx_ready_i) begin
			rx_valid_o <= 1'h0;
			rx_char_o <= ~rx_char_o;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_ucsr_top.sv
// self-checking bench of the serial control block
// assumes inputs change 1 ns after each rising edge
`timescale 1ns/1ns
`default_nettype none
module tb_ucsr_top import ucsr_pkg::*;;
	logic clock_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, bit_wr_i = 0;
	logic bit_val_i = 0, bit7_select_i = 0, baud_doubler_i = 0, send = 0;
	logic tx_eighth_end_i = 0, tx_stop_start_i = 0, rd_ready_i = 1;
	logic rx_valid_i, rx_ready_o, rd_valid_o, rx_enable_o, tx_ninth_bit_o;
	logic multiproc_filter_o;
	logic [7:0] sfr_addr_i = 8'h98, sfr_wdata_i = 8'h00, bit_addr_i = 8'h98;
	logic [7:0] sfr_rdata_o;
	logic [5:0] rate_div_o;
	ucsr_char_t rx_char_i, rd_char_o, sch = UCSR_CHAR_ZERO;
	ucsr_mode_t mode_o;
	int bad_count = 0, comparisons = 0;
	// rows: write data, doubler, mode, divisor
	localparam logic [16:0] ROWS [5] = '{{8'h00, 1'h0, 2'h0, 6'h06},
		{8'h40, 1'h0, 2'h1, 6'h00}, {8'h80, 1'h0, 2'h2, 6'h20},
		{8'h80, 1'h1, 2'h2, 6'h10}, {8'hC0, 1'h1, 2'h3, 6'h00}};
	always #20 clock_i = ~clock_i;
	ucsr_top dut_u (.*);
	ucsr_rx_node node_u (.clock_i, .send_i(send), .char_i(sch),
		.rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i), .rx_char_o(rx_char_i));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] d);
		sfr_wdata_i = d;
		sfr_wr_i = 1;
		tick(1);
		sfr_wr_i = 0;
	endtask
	task automatic rd(input logic [7:0] exp);
		sfr_rd_i = 1;
		tick(1);
		sfr_rd_i = 0;
		check(sfr_rdata_o, exp);
	endtask
	// bounded wait: a full buffer leaves the word with the node
	task automatic put(input logic [9:0] c);
		sch = c;
		send = 1;
		tick(1);
		send = 0;
		for (int i = 0; i < 20 && rx_valid_i; i++) tick(1);
		tick(1);
	endtask
	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		tick(2);
		rst_i = 0;
		check({rx_ready_o, rd_valid_o, rate_div_o}, {2'h2, 6'h06});
		rd(8'h00);
		foreach (ROWS[i]) begin
			{sfr_wdata_i, baud_doubler_i} = ROWS[i][16:8];
			wr(sfr_wdata_i);
			tick(1);
			check(mode_o, ROWS[i][7:6]);
			check(rate_div_o, ROWS[i][5:0]);
		end
		wr(8'h78);
		rd(8'h78);
		check({rx_enable_o, tx_ninth_bit_o, multiproc_filter_o}, 3'h7);
		bit7_select_i = 1;
		wr(8'hF8);
		rd(8'hF8);
		bit7_select_i = 0;
		rd(8'h78);
		bit7_select_i = 1;
		wr(8'h50);
		put({8'hA5, 2'h0});
		rd(8'hD1);
		put({8'h5A, 2'h1});
		rd(8'hD5);
		bit7_select_i = 0;
		wr(8'hF0);
		put({8'h11, 2'h1});
		rd(8'hF0);
		put({8'h22, 2'h3});
		rd(8'hF5);
		bit_wr_i = 1;
		tick(1);
		bit_wr_i = 0;
		rd(8'hF4);
		wr(8'h00);
		tx_stop_start_i = 1;
		tick(1);
		tx_stop_start_i = 0;
		rd(8'h00);
		tx_eighth_end_i = 1;
		tick(1);
		tx_eighth_end_i = 0;
		rd(8'h02);
		// stalled reader: two words fill the buffer, third waits
		wr(8'h50);
		rd_ready_i = 0;
		put({8'h01, 2'h1});
		put({8'h02, 2'h1});
		put({8'h03, 2'h1});
		check({rx_ready_o, rd_valid_o, rd_char_o.data}, 10'h101);
		rd_ready_i = 1;
		tick(1);
		check(rd_char_o.data, 8'h02);
		tick(4);
		// mid-run reset clears the hidden error flag and the buffer
		rst_i = 1;
		tick(2);
		rst_i = 0;
		check({rx_ready_o, rd_valid_o, rate_div_o}, {2'h2, 6'h06});
		bit7_select_i = 1;
		rd(8'h00);
		// shift mode: bad stop bit sets only rx-done, never the error
		put({8'h33, 2'h0});
		rd(8'h01);
		// hardware set beats a same-cycle software clear
		tx_eighth_end_i = 1;
		wr(8'h00);
		tx_eighth_end_i = 0;
		rd(8'h02);
		end_sim();
	end
	// watchdog well past the fewer than a hundred cycles of the sequence
	initial begin
		#20000;
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
